// ### scs_sequencer.sv
// Conversion sequencer: acquisition, switch sequencing, bit trials, result register.
// Assumes a clock enable from the system and a comparator answering within one cycle.
//
// How it works
// - A falling edge on convert_start_n requests a conversion, started only after acquisition completes.
// - Conversion first opens both grounding switches, then ties the arrays to reference ground.
// - Eighteen binary-weighted trials run MSB first, each decided by the comparator.
// - After the last trial the code is formed and then busy drops.
// - The result presented belongs to the conversion that just finished.
// - Coding select chooses binary or twos complement except in 18-bit parallel mode.
// - Binary maps to 00000/20000/3FFFF and twos complement to 20000/00000/1FFFF.
// - Overrange saturates to 3FFFF binary or 1FFFF twos complement.
// - Underrange saturates to 00000 binary or 20000 twos complement.
// - A started conversion always completes despite new requests or power down.
// - Convert start held low at acquisition end starts conversion at once.
// - The finished 18-bit result is kept in an output register.
`timescale 1ns/100ps

module scs_sequencer (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Host pins
  input wire logic convert_start_n_i,
  input wire logic coding_select_i,
  input wire logic power_down_in_i,
  output logic busy_o,
  output logic [17:0] result_o,
  // Capacitive array and comparator
  input wire logic comp_ge_i,
  output logic [17:0] dac_bits_o,
  output scs_pkg::scs_switch_t switch_o,
  // Wishbone slave
  input wire scs_pkg::scs_wb_req_t wb_i,
  output scs_pkg::scs_wb_rsp_t wb_o
);
  import scs_pkg::*;

  // ----------------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------------
  scs_state_t state, next_state;
  logic [ACQ_CNT_W-1:0] acq_cnt, next_acq_cnt;
  logic [4:0] bit_idx, next_bit_idx;
  logic [17:0] dac, next_dac;
  logic [17:0] result, next_result;
  logic cnv_prev, next_cnv_prev;
  logic [17:0] fmt_code;
  logic [1:0] mode;
  logic acq_done, start_edge;

  assign acq_done = (acq_cnt == ACQ_CNT_W'(ACQ_CYCLES - 1));
  assign start_edge = cnv_prev && !convert_start_n_i;

  scs_result_fmt u_fmt (
    .raw_i(dac),
    .binary_i(coding_select_i),
    .mode_i(mode),
    .code_o(fmt_code)
  );

  always_comb begin
    next_state = state;
    next_acq_cnt = acq_cnt;
    next_bit_idx = bit_idx;
    next_dac = dac;
    next_result = result;
    next_cnv_prev = convert_start_n_i;
    case (state)
      ST_ACQ: begin
        next_acq_cnt = acq_cnt + 1'b1;
        if (acq_done) begin
          next_acq_cnt = '0;
          // Low level at the end of tracking counts as a request
          if (!convert_start_n_i && !power_down_in_i) begin
            next_state = ST_SW_OPEN;
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        if (start_edge && !power_down_in_i) begin
          next_state = ST_SW_OPEN;
        end
      end
      ST_SW_OPEN: begin
        next_state = ST_SW_REF;
      end
      ST_SW_REF: begin
        next_dac = MSB_WEIGHT;
        next_bit_idx = MSB_IDX;
        next_state = ST_TRIAL;
      end
      ST_TRIAL: begin
        // No request or power down is looked at here, so nothing aborts
        if (!comp_ge_i) begin
          next_dac[bit_idx] = 1'b0;
        end
        if (bit_idx == 5'h00) begin
          next_state = ST_FORM;
        end else begin
          next_dac[bit_idx - 5'h01] = 1'b1;
          next_bit_idx = bit_idx - 5'h01;
        end
      end
      ST_FORM: begin
        // Saturation falls out of the search: all ones or all zeros
        next_result = fmt_code;
        next_state = ST_ACQ;
      end
      default: begin
        next_state = ST_ACQ;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= ST_ACQ;
      acq_cnt <= '0;
      bit_idx <= '0;
      dac <= '0;
      result <= '0;
      cnv_prev <= 1'b1;
    end else if (ce_i) begin
      state <= next_state;
      acq_cnt <= next_acq_cnt;
      bit_idx <= next_bit_idx;
      dac <= next_dac;
      result <= next_result;
      cnv_prev <= next_cnv_prev;
    end
  end

  // ----------------------------------------------------------------------
  // Switches and pins
  // ----------------------------------------------------------------------
  always_comb begin
    // Grounding switches stay closed only while tracking
    switch_o.pos_ground_switch = (state == ST_ACQ) || (state == ST_WAIT);
    switch_o.neg_ground_switch = (state == ST_ACQ) || (state == ST_WAIT);
    switch_o.input_connect = (state == ST_ACQ) || (state == ST_WAIT) || (state == ST_SW_OPEN);
    switch_o.reference_ground = !switch_o.input_connect;
  end

  assign busy_o = !((state == ST_ACQ) || (state == ST_WAIT)) || (state == ST_SW_OPEN);
  assign result_o = result;
  assign dac_bits_o = dac;

  // ----------------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------------
  logic ack, next_ack;
  logic [31:0] rdat, next_rdat;
  logic [1:0] next_mode;

  always_comb begin
    next_ack = wb_i.cyc && wb_i.stb && !ack;
    next_rdat = rdat;
    next_mode = mode;
    if (next_ack) begin
      next_rdat = '0;
      case (wb_i.adr)
        REG_CTRL: begin
          next_rdat[CTRL_MODE_LSB +: 2] = mode;
        end
        REG_STATUS: begin
          next_rdat[STAT_BUSY_BIT] = busy_o;
          next_rdat[STAT_STATE_LSB +: 6] = state;
        end
        REG_RESULT: begin
          next_rdat[17:0] = result;
        end
        default: begin
          next_rdat = '0;
        end
      endcase
    end
    // Write lands on the edge where the master sees ack, not one earlier
    if (ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0] && wb_i.adr == REG_CTRL) begin
      next_mode = wb_i.dat[CTRL_MODE_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= '0;
      mode <= CTRL_MODE_RST;
    end else if (ce_i) begin
      ack <= next_ack;
      rdat <= next_rdat;
      mode <= next_mode;
    end
  end

  assign wb_o.ack = ack;
  assign wb_o.dat = rdat;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  // Counts trial cycles per conversion so the trial count can be checked
  logic [4:0] trial_cnt, next_trial_cnt;

  always_comb begin
    next_trial_cnt = trial_cnt;
    if (state == ST_TRIAL) begin
      next_trial_cnt = trial_cnt + 5'h01;
    end else if (state == ST_ACQ) begin
      next_trial_cnt = '0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      trial_cnt <= '0;
    end else if (ce_i) begin
      trial_cnt <= next_trial_cnt;
    end
  end

  default clocking cb @(posedge clk_i iff ce_i); endclocking
  default disable iff (rst_i);

  // ----------------------------------------------------------------------
  // Conversion steps
  // ----------------------------------------------------------------------
  sequence s_open;
    !switch_o.pos_ground_switch && !switch_o.neg_ground_switch && switch_o.input_connect;
  endsequence
  sequence s_tie;
    !switch_o.input_connect && switch_o.reference_ground;
  endsequence
  // Busy covers two switch steps, 18 trials and the forming cycle
  sequence s_busy_run;
    busy_o[*8] ##1 busy_o[*8] ##1 busy_o[*5];
  endsequence

  // ----------------------------------------------------------------------
  // Start and switch sequencing
  // ----------------------------------------------------------------------
  a_wait_edge_start: assert property (state == ST_WAIT && start_edge && !power_down_in_i
    |=> state == ST_SW_OPEN) else $error("edge did not start conversion");
  a_no_early_start: assert property (state == ST_ACQ && !acq_done |=> state == ST_ACQ)
    else $error("conversion started before acquisition end");
  a_held_start: assert property (state == ST_ACQ && acq_done && !convert_start_n_i && !power_down_in_i
    |=> state == ST_SW_OPEN) else $error("held low did not start");
  a_switch_order: assert property ($fell(switch_o.pos_ground_switch) |-> s_open ##1 s_tie)
    else $error("switch order wrong");
  a_switch_open: assert property (busy_o |-> !switch_o.pos_ground_switch && !switch_o.neg_ground_switch)
    else $error("grounding switch closed while busy");

  // ----------------------------------------------------------------------
  // Bit trials
  // ----------------------------------------------------------------------
  a_msb_first: assert property (state == ST_SW_REF |=> dac == MSB_WEIGHT && bit_idx == MSB_IDX)
    else $error("first trial not the MSB");
  a_trial_count: assert property (state == ST_FORM |-> trial_cnt == 5'(RES_BITS))
    else $error("trial count not 18");
  a_trial_next: assert property (state == ST_TRIAL && bit_idx != 5'h00 |=> dac[$past(bit_idx) - 5'h01])
    else $error("next trial bit not set");
  a_trial_keep: assert property (state == ST_TRIAL && !comp_ge_i |=> dac[$past(bit_idx)] == 1'b0)
    else $error("trial bit kept on low compare");
  a_trial_hold: assert property (state == ST_TRIAL && comp_ge_i |=> dac[$past(bit_idx)] == 1'b1)
    else $error("trial bit dropped on high compare");
  a_no_abort: assert property ($rose(busy_o) |-> s_busy_run ##1 !busy_o)
    else $error("conversion aborted or overran");

  // ----------------------------------------------------------------------
  // Result forming and coding
  // ----------------------------------------------------------------------
  a_form_end: assert property (state == ST_FORM |=> state == ST_ACQ && !busy_o)
    else $error("busy not dropped after forming");
  a_busy_drop: assert property ($fell(busy_o)
    |-> $past(state) == ST_FORM && result_o == $past(fmt_code)) else $error("busy fell without formed result");
  a_result_hold: assert property (state != ST_FORM |=> $stable(result_o))
    else $error("result changed outside forming");
  a_par18_binary: assert property ($fell(busy_o) && mode == MODE_PAR18 |-> result_o == $past(dac))
    else $error("18-bit mode not binary");
  a_bin_select: assert property ($fell(busy_o) && mode != MODE_PAR18 && $past(coding_select_i)
    |-> result_o == $past(dac)) else $error("binary coding wrong");
  a_twos_msb: assert property ($fell(busy_o) && mode != MODE_PAR18 && !$past(coding_select_i)
    |-> result_o == ($past(dac) ^ MSB_WEIGHT)) else $error("twos complement wrong");
  a_sat_high: assert property (state == ST_TRIAL && bit_idx == 5'h00 && dac == 18'h3ffff && comp_ge_i
    ##1 1'b1 |=> result_o == ((mode != MODE_PAR18 && !$past(coding_select_i)) ? 18'h1ffff : 18'h3ffff))
    else $error("overrange not saturated");
  a_sat_low: assert property (state == ST_TRIAL && bit_idx == 5'h00 && dac == 18'h00001 && !comp_ge_i
    ##1 1'b1 |=> result_o == ((mode != MODE_PAR18 && !$past(coding_select_i)) ? 18'h20000 : 18'h00000))
    else $error("underrange not saturated");

  // ----------------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------------
  a_wb_ack: assert property (wb_i.cyc && wb_i.stb && !ack |=> ack)
    else $error("no bus answer");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack held longer than one cycle");
  a_mode_write: assert property (ack && wb_i.cyc && wb_i.stb && wb_i.we && wb_i.sel[0]
    && wb_i.adr == REG_CTRL |=> mode == $past(wb_i.dat[CTRL_MODE_LSB +: 2])) else $error("mode write lost");
endmodule : scs_sequencer

// ### scs_pkg_fmt.sv
// Package and output code formatter for the successive-approximation sequencer.
// Assumes a single 100 MHz clock; all inputs are synchronous to it.
`timescale 1ns/100ps
package scs_pkg;
  // ----------------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------------
  localparam int RES_BITS = 18;
  localparam int CLK_PERIOD_NS = 10;
  localparam int ACQ_TIME_NS = 1000;
  localparam int ACQ_CYCLES = (ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACQ_CNT_W = 8;
  localparam logic [4:0] MSB_IDX = 5'h11;
  localparam logic [17:0] MSB_WEIGHT = 18'h20000;

  // ----------------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RESULT = 4'h8;
  localparam int CTRL_MODE_LSB = 0;
  localparam logic [1:0] CTRL_MODE_RST = 2'h0;
  localparam logic [1:0] MODE_PAR18 = 2'h0;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_STATE_LSB = 1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [5:0] {
    ST_ACQ = 6'h01,
    ST_WAIT = 6'h02,
    ST_SW_OPEN = 6'h04,
    ST_SW_REF = 6'h08,
    ST_TRIAL = 6'h10,
    ST_FORM = 6'h20
  } scs_state_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [3:0] adr;
    logic [31:0] dat;
  } scs_wb_req_t;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } scs_wb_rsp_t;

  typedef struct packed {
    logic pos_ground_switch;
    logic neg_ground_switch;
    logic input_connect;
    logic reference_ground;
  } scs_switch_t;
endpackage : scs_pkg

// Straight binary to selected coding; 18-bit parallel mode forces binary.
module scs_result_fmt (
  // Raw code and selection
  input wire logic [17:0] raw_i,
  input wire logic binary_i,
  input wire logic [1:0] mode_i,
  // Formatted code
  output logic [17:0] code_o
);
  import scs_pkg::*;

  always_comb begin
    if (binary_i || mode_i == MODE_PAR18) begin
      code_o = raw_i;
    end else begin
      code_o = raw_i ^ MSB_WEIGHT;
    end
  end
endmodule : scs_result_fmt

// ### scs_comp_model.sv
// Comparator and capacitive array model for the sequencer bench.
// Assumes the array tracks the input while connected and holds it after.
`timescale 1ns/100ps

module scs_comp_model (
  // Array side
  input wire logic clk_i,
  input wire scs_pkg::scs_switch_t switch_i,
  input wire logic [17:0] dac_bits_i,
  input wire logic signed [31:0] level_i,
  // Decision
  output logic comp_ge_o
);
  import scs_pkg::*;
  int held = 0;

  // Out of span inputs pin the held charge to the rails
  always @(posedge clk_i) begin
    if (switch_i.input_connect) begin
      held <= (level_i < 0) ? 0 : (level_i > 262143) ? 262143 : level_i;
    end
  end

  assign comp_ge_o = (held >= int'(dac_bits_i));
endmodule : scs_comp_model

// ### scs_sequencer_tb.sv
// Self-checking bench for the conversion sequencer.
// Assumes the comparator model answers combinationally from the array bits.
`timescale 1ns/100ps

module scs_sequencer_tb;
  import scs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cs_n = 1'b0;
  logic coding_select = 1'b1;
  logic pd = 1'b0;
  logic ce = 1'b1;
  logic comp_ge;
  logic busy;
  logic [17:0] result;
  logic [17:0] dac;
  scs_switch_t sw;
  scs_wb_req_t wb_req = '0;
  scs_wb_rsp_t wb_rsp;
  int level = 0;
  int seed = 32'h73d0;
  int num_errors = 0;
  int comparisons = 0;
  int mode = 0;
  int levels[5] = '{0, 131072, 262143, 300000, -7};
  logic [31:0] rd;

  always #5 clk_i = ~clk_i;

  scs_sequencer scs_sequencer_inst (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .convert_start_n_i(cs_n),
    .coding_select_i(coding_select), .power_down_in_i(pd), .busy_o(busy), .result_o(result),
    .comp_ge_i(comp_ge), .dac_bits_o(dac), .switch_o(sw), .wb_i(wb_req), .wb_o(wb_rsp));
  scs_comp_model scs_comp_model_inst (.clk_i(clk_i), .switch_i(sw), .dac_bits_i(dac), .level_i(level),
    .comp_ge_o(comp_ge));

  // ----------------------------------------------------------------------
  // Checking and reporting
  // ----------------------------------------------------------------------
  task automatic finish_test;
    if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : finish_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
      num_errors++;
    end
  endtask : chk

  task automatic hang;
    num_errors++;
    finish_test();
  endtask : hang

  function automatic logic [31:0] model_code(input int a, input logic cs, input int m);
    int c;
    c = (a < 0) ? 0 : (a > 262143) ? 262143 : a;
    if (m != 0 && cs == 1'b0) c = c ^ 131072;
    return 32'(c);
  endfunction : model_code

  // ----------------------------------------------------------------------
  // Bus and conversion drivers
  // ----------------------------------------------------------------------
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wdat);
    int i;
    @(posedge clk_i);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: adr, dat: wdat};
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      if (wb_rsp.ack === 1'b1) break;
    end
    if (i == 20) hang();
    rd = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb_xfer

  // Abuse pulses a new request and power down in mid conversion
  // Stall freezes the block through its clock enable for that many cycles
  task automatic convert(input int a, input logic cs, input logic abuse, input int stall);
    int i;
    int n;
    @(posedge clk_i);
    level <= a;
    coding_select <= cs;
    cs_n <= 1'b0;
    for (i = 0; i < 300; i++) begin
      @(posedge clk_i);
      if (busy === 1'b1) break;
    end
    if (i == 300) hang();
    cs_n <= 1'b1;
    for (n = 1; n < 40; n++) begin
      if (n < 3) chk("switches", (n == 1) ? 32'h2 : 32'h1, {28'h0, sw});
      if (n == 3) chk("first trial", 32'h20000, {14'h0, dac});
      if (abuse && n == 6) begin
        cs_n <= 1'b0;
        pd <= 1'b1;
      end
      if (stall > 0 && n == 8) ce <= 1'b0;
      if (stall > 0 && n == 8 + stall) ce <= 1'b1;
      @(posedge clk_i);
      if (busy !== 1'b1) break;
    end
    chk("busy cycles", 32'h15 + 32'(stall), 32'(n));
    chk("result", model_code(a, cs, mode), {14'h0, result});
    pd <= 1'b0;
    cs_n <= 1'b1;
  endtask : convert

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int m;
    int c;
    int k;
    int a;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_xfer(1'b0, REG_STATUS, 32'h0);
    chk("status", 32'h2, rd);
    convert(131072, 1'b1, 1'b0, 0);
    for (m = 0; m < 2; m++) begin
      wb_xfer(1'b1, REG_CTRL, 32'(m));
      mode = m;
      wb_xfer(1'b0, REG_CTRL, 32'h0);
      chk("mode", 32'(m), rd);
      for (c = 0; c < 2; c++) begin
        for (k = 0; k < 8; k++) begin
          a = (k < 5) ? levels[k] : int'($unsigned($random(seed)) % 262144);
          if (k == 3) repeat (110) @(posedge clk_i);
          convert(a, c[0], k == 4, (k == 5) ? 3 : 0);
        end
        wb_xfer(1'b0, REG_RESULT, 32'h0);
        chk("result reg", model_code(a, c[0], m), rd);
      end
    end
    wb_xfer(1'b1, 4'hc, 32'h5);
    wb_xfer(1'b0, 4'hc, 32'h0);
    chk("unmapped", 32'h0, rd);
    finish_test();
  end
endmodule : scs_sequencer_tb
